/* bench/dpsem_dev.sv */
// behavioural two-port semaphore device; far port driven by the bench
`timescale 1ns/1ps
module dpsem_dev
    import dpsem_pkg::*;
(
    input wire logic i_clk,
    input wire dpsem_pins_type i_pins,
    input wire logic [35:0] i_data,
    input wire logic i_far_we,
    input wire logic [2:0] i_far_idx,
    input wire logic i_far_val,
    output logic [35:0] o_data
);
    // no power-up clearing: latches start as pending zeros
    logic [7:0] near_q = 8'h00;
    logic [7:0] far_q = 8'h00;
    logic [7:0] own_n_q = 8'h00;
    logic [7:0] own_f_q = 8'h00;
    logic flag_q = 1'b1;
    wire sel = !i_pins.semaphore_select_n && i_pins.byte_lane_enables_n == 4'h0;
    wire wr = sel && !i_pins.rw_n;
    wire rd = sel && !i_pins.output_enable_n;
    // first zero wins, near side on a tie; release hands over to a pending zero
    wire [7:0] own_n_d = ~near_q & (own_n_q | ~own_f_q);
    wire [7:0] own_f_d = ~far_q & (own_f_q | ~own_n_d);
    // value replicated on all bits; inverse shown while not reading
    assign o_data = rd ? {36{flag_q}} : {36{~flag_q}};
    always @(posedge i_clk) begin
        if (wr) begin
            near_q[i_pins.flag_index_bits] <= i_data[0];
        end
        if (i_far_we) begin
            far_q[i_far_idx] <= i_far_val;
        end
        own_n_q <= own_n_d;
        own_f_q <= own_f_d;
        if (!rd) begin
            flag_q <= !own_n_q[i_pins.flag_index_bits];
        end
    end
endmodule

/* bench/dpsem_host_checker.sv */
// port assertions for the semaphore host
`timescale 1ns/1ps
module dpsem_host_checker
    import dpsem_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_req_valid,
    input wire dpsem_req_type i_req,
    input wire logic o_req_ready,
    input wire logic o_done,
    input wire logic o_flag,
    input wire logic o_owned,
    input wire logic o_init_busy,
    input wire dpsem_pins_type o_pins,
    input wire logic [35:0] o_data_out,
    input wire logic o_data_oe
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // a take is accepted on this edge
    wire take = i_req_valid && o_req_ready && i_req.op == DPSEM_OP_TAKE;
    AST_OWNED: assert property (o_done |-> o_owned == !o_flag)
        else $error("owned disagrees with flag");
    AST_WR_SEL: assert property (o_data_oe |-> !o_pins.semaphore_select_n && !o_pins.rw_n)
        else $error("write without select");
    AST_RD_SEL: assert property (!o_pins.output_enable_n |-> !o_pins.semaphore_select_n
        && o_pins.byte_lane_enables_n == 4'h0 && !o_data_oe) else $error("bad read strobes");
    AST_CS_OFF: assert property (o_pins.chip_select_low_n && !o_pins.chip_select_high)
        else $error("memory selected");
    AST_INIT_ONE: assert property (o_init_busy && o_data_oe |-> o_data_out[0])
        else $error("init wrote zero");
    AST_INIT_WAIT: assert property (o_init_busy |-> !o_req_ready)
        else $error("ready during init");
    AST_TAKE_WR: assert property (take |-> ##[1:3] (o_data_oe && !o_data_out[0]))
        else $error("take did not write zero");
    AST_TAKE_ORDER: assert property (take |=> o_pins.output_enable_n [*8])
        else $error("take read before write");
endmodule
bind dpsem_host dpsem_host_checker chk_u (.i_clk(i_clk), .i_rst(i_rst),
    .i_req_valid(i_req_valid), .i_req(i_req), .o_req_ready(o_req_ready), .o_done(o_done),
    .o_flag(o_flag), .o_owned(o_owned), .o_init_busy(o_init_busy), .o_pins(o_pins),
    .o_data_out(o_data_out), .o_data_oe(o_data_oe));

/* bench/tb_top.sv */
// self-checking bench for the semaphore host
`timescale 1ns/1ps
module tb_top;
    import dpsem_pkg::*;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_req_valid = 1'b0;
    dpsem_req_type i_req = '0;
    logic o_req_ready, o_done, o_flag, o_owned, o_init_busy, o_data_oe;
    dpsem_pins_type o_pins;
    logic [35:0] o_data_out, i_data_in;
    logic far_we = 1'b0;
    logic [2:0] far_idx = 3'h0;
    logic far_val = 1'b1;
    int fail_count = 0;
    int checked = 0;
    int cyc = 0;
    always #2 i_clk = ~i_clk;
    dpsem_host dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_req_valid(i_req_valid), .i_req(i_req),
        .o_req_ready(o_req_ready), .o_done(o_done), .o_flag(o_flag), .o_owned(o_owned),
        .o_init_busy(o_init_busy), .o_pins(o_pins), .o_data_out(o_data_out),
        .o_data_oe(o_data_oe), .i_data_in(i_data_in));
    dpsem_dev dev_u (.i_clk(i_clk), .i_pins(o_pins), .i_data(o_data_out), .i_far_we(far_we),
        .i_far_idx(far_idx), .i_far_val(far_val), .o_data(i_data_in));
    task automatic end_sim();
        $display("fail_count %0d checked %0d", fail_count, checked);
        if (fail_count == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic got, input logic exp, input string msg);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t %s", $time, msg);
        end
    endtask
    // offer one request, hold it until taken, then wait for done
    task automatic op(input dpsem_op_type o, input logic [2:0] idx, input logic v);
        @(negedge i_clk);
        i_req = '{o, idx, v};
        i_req_valid = 1'b1;
        while (o_req_ready !== 1'b1) @(negedge i_clk);
        @(negedge i_clk);
        i_req_valid = 1'b0;
        while (o_done !== 1'b1) @(negedge i_clk);
    endtask
    // the far port writes one latch
    task automatic far(input logic [2:0] idx, input logic v);
        @(negedge i_clk);
        far_we = 1'b1;
        far_idx = idx;
        far_val = v;
        @(negedge i_clk);
        far_we = 1'b0;
    endtask
    task automatic t_take_free();
        op(DPSEM_OP_TAKE, 3'h7, 1'b0);
        chk(o_owned, 1'b1, "take free");
        chk(o_flag, 1'b0, "flag held");
        far(3'h7, 1'b0);
        op(DPSEM_OP_READ, 3'h7, 1'b0);
        chk(o_flag, 1'b0, "kept after far zero");
    endtask
    task automatic t_handover();
        op(DPSEM_OP_GIVE, 3'h7, 1'b1);
        chk(dev_u.own_f_q[7], 1'b1, "handover");
        op(DPSEM_OP_READ, 3'h7, 1'b0);
        chk(o_flag, 1'b1, "reads lost");
        far(3'h7, 1'b1);
    endtask
    task automatic t_take_lost();
        far(3'h2, 1'b0);
        op(DPSEM_OP_TAKE, 3'h2, 1'b0);
        chk(o_owned, 1'b0, "take lost");
        chk(dev_u.near_q[2], 1'b1, "withdrawn");
        far(3'h2, 1'b1);
        op(DPSEM_OP_TAKE, 3'h2, 1'b0);
        chk(o_owned, 1'b1, "retake");
    endtask
    task automatic t_write();
        op(DPSEM_OP_WRITE, 3'h4, 1'b0);
        chk(dev_u.near_q[4], 1'b0, "plain write zero");
        op(DPSEM_OP_READ, 3'h4, 1'b1);
        chk(o_owned, 1'b1, "plain write owns");
        op(DPSEM_OP_WRITE, 3'h4, 1'b1);
        chk(dev_u.near_q[4], 1'b1, "plain write one");
    endtask
    // a hang counts as a mismatch
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 20000) begin
            $display("ERROR %0t timeout", $time);
            fail_count++;
            end_sim();
        end
    end
    initial begin
        repeat (4) @(posedge i_clk);
        @(negedge i_clk);
        i_rst = 1'b0;
        for (int i = 0; i < 8; i++) far(i[2:0], 1'b1);
        while (o_init_busy !== 1'b0) @(negedge i_clk);
        chk(dev_u.near_q === 8'hff, 1'b1, "init walk");
        t_take_free();
        t_handover();
        t_take_lost();
        t_write();
        end_sim();
    end
endmodule

/* core/dpsem_host.sv */
// host controller that drives one semaphore port of the dual-port memory
`timescale 1ns/1ps
`include "dpsem_map.svh"
module dpsem_host
    import dpsem_pkg::*;
#(
    parameter int DATA_W = `DPSEM_DATA_W,
    parameter int ACC_CYC = `DPSEM_ACC_CYC,
    parameter int GAP_CYC = `DPSEM_GAP_CYC,
    parameter int RETRIES = 4
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_req_valid,
    input wire dpsem_req_type i_req,
    output logic o_req_ready,
    output logic o_done,
    output logic o_flag,
    output logic o_owned,
    output logic o_init_busy,
    output dpsem_pins_type o_pins,
    output logic [DATA_W-1:0] o_data_out,
    output logic o_data_oe,
    input wire logic [DATA_W-1:0] i_data_in
);
    typedef enum logic [2:0] {
        DPSEM_INIT,
        DPSEM_IDLE,
        DPSEM_WR,
        DPSEM_RD,
        DPSEM_GAP,
        DPSEM_FIN
    } dpsem_state_type;

    localparam int TW = 8;

    dpsem_state_type state_q, state_d;
    dpsem_req_type cur_q;
    logic [`DPSEM_IDX_W-1:0] init_idx_q;
    logic then_read_q, wd_q;
    logic [7:0] tries_q;
    logic flag_q, owned_q, done_q;
    logic [DATA_W-1:0] s1_q, s2_q, s3_q;
    logic timer_load, timer_done;
    logic [TW-1:0] timer_count;

    // all-ones or all-zeros from the far end; the single stable bit DPSEM_FLAG_BIT is taken
    function automatic logic dpsem_flag_of(input logic [DATA_W-1:0] v);
        return v[`DPSEM_FLAG_BIT];
    endfunction

    // data pins cross from outside: three stages, change taken when two and three agree
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= i_data_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    wire in_agree = (s2_q == s3_q);
    wire rd_flag = dpsem_flag_of(s3_q);

    wire accepting = (state_q == DPSEM_IDLE);
    assign o_req_ready = accepting;
    wire take_req = accepting && i_req_valid;
    wire is_take = (cur_q.op == DPSEM_OP_TAKE);

    // phase timer: access time plus three cycles per strobe phase, gap between phases
    wire enter_phase = take_req || (state_q == DPSEM_GAP && timer_done)
        || (state_q == DPSEM_INIT && timer_done && state_d == DPSEM_WR);
    wire wr_end = (state_q == DPSEM_WR) && timer_done;
    wire rd_end = (state_q == DPSEM_RD) && timer_done && in_agree;
    assign timer_load = enter_phase || wr_end || rd_end
        || (state_q == DPSEM_INIT && timer_done);
    assign timer_count = (wr_end || rd_end) ? TW'(GAP_CYC) : TW'(ACC_CYC + 3);

    dpsem_timer #(
        .WIDTH(TW)
    ) u_timer (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_load(timer_load),
        .i_count(timer_count),
        .o_done(timer_done)
    );

    // sequencing; init walks every flag writing one
    always_comb begin
        state_d = state_q;
        case (state_q)
            DPSEM_INIT: begin
                if (timer_done) begin
                    state_d = DPSEM_WR;
                end
            end
            DPSEM_IDLE: begin
                if (i_req_valid) begin
                    state_d = (i_req.op == DPSEM_OP_READ) ? DPSEM_RD : DPSEM_WR;
                end
            end
            DPSEM_WR: begin
                if (timer_done) begin
                    state_d = DPSEM_GAP;
                end
            end
            DPSEM_RD: begin
                if (rd_end) begin
                    state_d = DPSEM_GAP;
                end
            end
            DPSEM_GAP: begin
                if (timer_done) begin
                    state_d = then_read_q ? DPSEM_RD : (wd_q ? DPSEM_WR : DPSEM_FIN);
                end
            end
            DPSEM_FIN: begin
                state_d = (o_init_busy && init_idx_q != '1) ? DPSEM_WR : DPSEM_IDLE;
            end
            default: begin
                state_d = DPSEM_IDLE;
            end
        endcase
    end

    logic init_q;
    assign o_init_busy = init_q;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state_q <= DPSEM_INIT;
        end else begin
            state_q <= state_d;
        end
    end

    // request capture and init walk
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cur_q <= '{op: DPSEM_OP_WRITE, index: '0, value: 1'b1};
            init_idx_q <= '0;
            init_q <= 1'b1;
        end else if (take_req) begin
            cur_q <= i_req;
        end else if (state_q == DPSEM_FIN && init_q) begin
            if (init_idx_q == '1) begin
                init_q <= 1'b0;
            end else begin
                init_idx_q <= init_idx_q + 1'b1;
                cur_q.index <= init_idx_q + 1'b1;
            end
        end
    end

    // a lost poll with budget left reads again; the last lost poll arms the withdrawal
    wire more_polls = (tries_q + 8'd1) < 8'(RETRIES);

    // take writes zero then reads back; failure retries reading then withdraws
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            then_read_q <= 1'b0;
            tries_q <= '0;
            wd_q <= 1'b0;
        end else if (take_req) begin
            then_read_q <= (i_req.op == DPSEM_OP_TAKE);
            tries_q <= '0;
            wd_q <= 1'b0;
        end else if (wr_end) begin
            then_read_q <= is_take && (tries_q == '0);
            wd_q <= 1'b0; // one withdrawing write only, else the take would loop
        end else if (rd_end) begin
            tries_q <= tries_q + 1'b1;
            // keep polling while lost, until the retry budget runs out
            then_read_q <= is_take && rd_flag && more_polls;
            wd_q <= is_take && rd_flag && !more_polls;
        end
    end

    // a take that loses every poll ends in a withdrawing write of one; a pending zero
    // left behind would lock the far side out for good
    wire withdraw = wd_q;

    // results: a zero read means this side holds the token
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            flag_q <= 1'b1;
            owned_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= (state_q == DPSEM_FIN) && !init_q;
            if (rd_end) begin
                flag_q <= rd_flag;
                owned_q <= !rd_flag;
            end
        end
    end

    assign o_done = done_q;
    assign o_flag = flag_q;
    assign o_owned = owned_q;

    // written value: zero for take, one for give, init and withdraw
    wire wr_val = init_q ? 1'b1
        : (cur_q.op == DPSEM_OP_TAKE) ? (withdraw ? 1'b1 : 1'b0)
        : (cur_q.op == DPSEM_OP_GIVE) ? 1'b1 : cur_q.value;
    wire drv_wr = (state_q == DPSEM_WR);
    wire drv_rd = (state_q == DPSEM_RD);

    // pins registered; only the low address bits and data bit zero matter
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_pins <= '{semaphore_select_n: 1'b1, chip_select_low_n: 1'b1,
                chip_select_high: 1'b0, rw_n: 1'b1, output_enable_n: 1'b1,
                byte_lane_enables_n: '1, flag_index_bits: '0};
            o_data_out <= '0;
            o_data_oe <= 1'b0;
        end else begin
            o_pins.semaphore_select_n <= !(drv_wr || drv_rd);
            o_pins.chip_select_low_n <= 1'b1; // memory array stays deselected
            o_pins.chip_select_high <= 1'b0;
            o_pins.rw_n <= !drv_wr;
            o_pins.output_enable_n <= !drv_rd;
            o_pins.byte_lane_enables_n <= (drv_wr || drv_rd) ? '0 : '1;
            o_pins.flag_index_bits <= cur_q.index;
            o_data_out <= {{(DATA_W-1){1'b0}}, wr_val};
            o_data_oe <= drv_wr;
        end
    end
endmodule

/* core/dpsem_map.svh */
// timing counts and field positions for the semaphore port controller
`ifndef DPSEM_MAP_SVH
`define DPSEM_MAP_SVH
`define DPSEM_NUM_FLAGS 8
`define DPSEM_IDX_W 3
`define DPSEM_DATA_W 36
`define DPSEM_LANES 4
`define DPSEM_FLAG_BIT 0
`define DPSEM_CLK_NS 4
`define DPSEM_ACC_NS 20
`define DPSEM_ACC_CYC ((`DPSEM_ACC_NS + `DPSEM_CLK_NS - 1) / `DPSEM_CLK_NS)
`define DPSEM_GAP_NS 8
`define DPSEM_GAP_CYC ((`DPSEM_GAP_NS + `DPSEM_CLK_NS - 1) / `DPSEM_CLK_NS)
`endif

/* core/dpsem_pkg.sv */
// types for the semaphore port controller
`include "dpsem_map.svh"
package dpsem_pkg;
    typedef enum logic [1:0] {
        DPSEM_OP_WRITE,
        DPSEM_OP_READ,
        DPSEM_OP_TAKE,
        DPSEM_OP_GIVE
    } dpsem_op_type;

    typedef struct packed {
        dpsem_op_type op;
        logic [`DPSEM_IDX_W-1:0] index;
        logic value;
    } dpsem_req_type;

    typedef struct packed {
        logic semaphore_select_n;
        logic chip_select_low_n;
        logic chip_select_high;
        logic rw_n;
        logic output_enable_n;
        logic [`DPSEM_LANES-1:0] byte_lane_enables_n;
        logic [`DPSEM_IDX_W-1:0] flag_index_bits;
    } dpsem_pins_type;
endpackage

/* core/dpsem_timer.sv */
// cycle counter that paces each pin phase
`timescale 1ns/1ps
module dpsem_timer
    import dpsem_pkg::*;
#(
    parameter int WIDTH = 4
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_load,
    input wire logic [WIDTH-1:0] i_count,
    output logic o_done
);
    logic [WIDTH-1:0] cnt_q;

    // counts down to zero; done while idle at zero
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_q <= '0;
        end else if (i_load) begin
            cnt_q <= i_count;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    // done ignores the load: the load is decoded from done, so gating it would close a loop
    assign o_done = (cnt_q == '0);
endmodule
